//--- src/aux_ram.sv
// Purpose: on-chip auxiliary data RAM, one registered read port
// Assumes: one access per cycle
// Notes:   array has no reset, its content is undefined at power-up
`timescale 1ns/1ps
module aux_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1024,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             we,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata_q
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_q[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= mem_q[addr];
    end
  end
endmodule

//--- src/data_memory_map_and_xbus.sv
// Purpose: data memory map, register banks, bit areas and MOVX routing
// Assumes: one byte, one bit and one MOVX request at most per cycle
// Notes:   SFRs other than the bus timing and aux control bytes are
//          forwarded on the sfr port; bit SFRs never hit local bytes
`timescale 1ns/1ps

// Operation
// R1: Code comes only from on-chip flash; no external code fetch path.
// R2: After any reset, fetch starts at address 0000H.
// R3: Accepted interrupt branches to 0003H plus eight bytes per source.
// R4: 256 bytes internal RAM; lower half by direct and indirect access.
// R5: Upper half: indirect goes to RAM, direct goes to SFR space.
// R6: Bytes 00H-1FH form four banks of eight registers, chosen by PROGRAM_STATUS_WORD.
// R7: Register operands resolve only inside the selected bank.
// R8: Bit addresses 00H-7FH map onto RAM bytes 20H-2FH.
// R9: Only SFRs whose address ends in 0H or 8H are bit-addressable.
// R10: With aux RAM enabled, MOVX 0000H-03FFH hits on-chip aux RAM.
// R11: Aux disable bit, control bit 1, blocks all aux RAM access.
// R12: Enabled aux RAM and address above 03FFH uses the external bus.
// R13: With aux RAM enabled, 8-bit indirect MOVX ignores pointer high byte.
// R14: 64K external data space over two ports, latch and two strobes.
// R15: Bus timing register at SFR A1H stretches external MOVX cycles.
// R16: Two-bit field stretches address setup and hold around latch fall.
// R17: Three-bit field stretches read and write strobe width.
// R18: Flash commands outside the requester's permitted region are ignored.
// R19: Setup/hold codes 00-11 give one to four cycles; reset three.
// R20: Strobe codes 000-111 give one to eight cycles; reset code 011.
// R21: Aux RAM accesses ignore the bus timing settings.
// R22: Low address on p0 latched by latch fall; high address on p2.
// R23: External memory gives read data and takes write data in strobe.
module data_memory_map_and_xbus
  import data_memory_map_pkg::*;
#(
  parameter int          AUX_DEPTH = 1024,
  parameter logic [15:0] AP_END    = 16'h8000,
  parameter logic [15:0] IAP_END   = 16'hC000
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [15:0] pc_next,
  input  wire logic        irq_accept,
  input  wire logic [2:0]  irq_index,
  output logic      [15:0] fetch_addr_q,
  input  wire logic [1:0]  psw_bank,
  input  wire byte_req_s   byte_req,
  output logic      [7:0]  byte_rdata_q,
  input  wire bit_req_s    bit_req,
  output logic             bit_rdata_q,
  output logic             sfr_valid,
  output logic             sfr_we,
  output logic      [7:0]  sfr_addr,
  output logic      [7:0]  sfr_wdata,
  input  wire logic [7:0]  sfr_rdata,
  output logic             sfr_bit_valid,
  output logic             sfr_bit_we,
  output logic      [7:0]  sfr_bit_byte,
  output logic      [2:0]  sfr_bit_pos,
  output logic             sfr_bit_value,
  input  wire logic        sfr_bit_rdata,
  input  wire movx_req_s   movx_req,
  output logic             movx_ready,
  output logic             movx_done,
  output logic      [7:0]  movx_rdata,
  input  wire logic        flash_cmd_valid,
  input  wire logic [15:0] flash_cmd_addr,
  input  wire logic        flash_req_isp,
  input  wire logic        isp_data_en,
  output logic             flash_cmd_go,
  output logic             flash_cmd_fail_q,
  input  wire logic [7:0]  p0_in,
  output logic      [7:0]  p0_out,
  output logic             p0_oe,
  output logic      [7:0]  p2_out,
  output logic             ale,
  output logic             rd_n,
  output logic             wr_n
);
  localparam int AW = $clog2(AUX_DEPTH);

  logic [7:0]  iram_q [256];
  logic [7:0]  timing_q;
  logic        aux_dis_q;
  logic        aux_done_q;

  // Program fetch: flash only, vectors eight bytes apart
  logic [15:0] vector_addr;
  assign vector_addr = VECTOR_BASE +
                       ({13'h0000, irq_index} << VECTOR_SHIFT); // R3

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetch_addr_q <= RESET_VECTOR; // R2
    end
    else
    begin
      fetch_addr_q <= irq_accept ? vector_addr : pc_next; // R1 R3
    end
  end

  // Byte path decode
  logic [7:0] byte_ram_addr;
  logic       byte_is_sfr, byte_to_ram;
  logic       hit_timing, hit_aux_ctrl;
  assign byte_ram_addr = byte_req.reg_mode ?
    {3'b000, psw_bank, byte_req.addr[2:0]} : byte_req.addr; // R6 R7
  assign byte_is_sfr  = byte_req.valid && !byte_req.reg_mode &&
                        !byte_req.indirect && byte_req.addr[7]; // R5
  assign byte_to_ram  = byte_req.valid && !byte_is_sfr; // R4 R5
  assign hit_timing   = byte_is_sfr &&
                        byte_req.addr == BUS_TIMING_ADDR; // R15
  assign hit_aux_ctrl = byte_is_sfr && byte_req.addr == AUX_CTRL_ADDR;
  assign sfr_valid    = byte_is_sfr && !hit_timing && !hit_aux_ctrl;
  assign sfr_we       = byte_req.we;
  assign sfr_addr     = byte_req.addr;
  assign sfr_wdata    = byte_req.wdata;

  logic [7:0] local_rdata;
  assign local_rdata = hit_timing ? (timing_q & TIMING_MASK) :
    hit_aux_ctrl ? (8'h00 | (8'({aux_dis_q}) << AUX_DISABLE_BIT)) :
    sfr_rdata;

  // Bit path decode: low bit space in RAM, high space in SFRs
  logic       bit_in_ram;
  logic [7:0] bit_byte_addr;
  assign bit_in_ram    = !bit_req.addr[7]; // R8
  assign bit_byte_addr = {BIT_AREA_HI, bit_req.addr[6:3]}; // R8
  assign sfr_bit_valid = bit_req.valid && !bit_in_ram;
  assign sfr_bit_we    = bit_req.we;
  assign sfr_bit_byte  = {bit_req.addr[7:3], 3'b000}; // R9
  assign sfr_bit_pos   = bit_req.addr[2:0];
  assign sfr_bit_value = bit_req.value;

  // RAM array has no reset; its content is random at power-up
  always_ff @(posedge clk)
  begin
    if (byte_to_ram && byte_req.we)
    begin
      iram_q[byte_ram_addr] <= byte_req.wdata; // R4
    end
    else if (bit_req.valid && bit_req.we && bit_in_ram)
    begin
      iram_q[bit_byte_addr][bit_req.addr[2:0]] <= bit_req.value; // R8
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      byte_rdata_q <= 8'h00;
      bit_rdata_q  <= 1'b0;
      timing_q     <= BUS_TIMING_RESET; // R19 R20
      aux_dis_q    <= AUX_DIS_RESET;
    end
    else
    begin
      byte_rdata_q <= byte_to_ram ? iram_q[byte_ram_addr] : local_rdata;
      bit_rdata_q  <= bit_in_ram ?
        iram_q[bit_byte_addr][bit_req.addr[2:0]] : sfr_bit_rdata;
      if (hit_timing && byte_req.we)
      begin
        timing_q <= byte_req.wdata & TIMING_MASK; // R15
      end
      if (hit_aux_ctrl && byte_req.we)
      begin
        aux_dis_q <= byte_req.wdata[AUX_DISABLE_BIT]; // R11
      end
    end
  end

  // MOVX routing
  logic [15:0] movx_addr;
  logic        in_aux, movx_take, xbus_start, xbus_busy, xbus_done;
  logic [7:0]  xbus_rdata, aux_rdata;
  xbus_cmd_s   xbus_cmd;
  assign movx_addr[7:0]  = movx_req.via_ri ? movx_req.ri :
                           movx_req.dptr[7:0];
  assign movx_addr[15:8] = (movx_req.via_ri && !aux_dis_q) ? 8'h00 :
                           movx_req.dptr[15:8]; // R13
  assign in_aux     = !aux_dis_q && movx_addr <= AUX_LAST; // R10 R11
  assign movx_ready = !xbus_busy;
  assign movx_take  = movx_req.valid && movx_ready;
  assign xbus_start = movx_take && !in_aux; // R12 R14
  assign xbus_cmd   = '{we: movx_req.we, addr: movx_addr,
                        wdata: movx_req.wdata};
  assign movx_done  = aux_done_q || xbus_done;
  assign movx_rdata = aux_done_q ? aux_rdata : xbus_rdata;

  logic aux_we;
  assign aux_we = movx_take && in_aux && movx_req.we; // R10 R21

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aux_done_q <= 1'b0;
    end
    else
    begin
      aux_done_q <= movx_take && in_aux; // R21
    end
  end

  aux_ram #(
    .WIDTH (8),
    .DEPTH (AUX_DEPTH)
  ) u_aux_ram (
    .clk     (clk),
    .resetn  (resetn),
    .we      (aux_we),
    .addr    (movx_addr[AW-1:0]),
    .wdata   (movx_req.wdata),
    .rdata_q (aux_rdata)
  );

  xbus_engine u_xbus (
    .clk        (clk),
    .resetn     (resetn),
    .start      (xbus_start),
    .cmd        (xbus_cmd),
    .latch_code (timing_q[LATCH_LSB +: 2]), // R16 R19
    .width_code (timing_q[WIDTH_LSB +: 3]), // R17 R20
    .busy       (xbus_busy),
    .done_q     (xbus_done),
    .rdata_q    (xbus_rdata),
    .p0_in      (p0_in),
    .p0_out     (p0_out),
    .p0_oe      (p0_oe),
    .p2_out     (p2_out),
    .ale        (ale),
    .rd_n       (rd_n),
    .wr_n       (wr_n)
  );

  // Flash command guard; a refused command is dropped, not queued
  flash_region_e target;
  logic          allowed;
  assign target  = (flash_cmd_addr < AP_END)  ? REGION_AP :
                   (flash_cmd_addr < IAP_END) ? REGION_IAP : REGION_ISP;
  assign allowed = flash_req_isp ? (target != REGION_ISP || isp_data_en)
                                 : (target == REGION_IAP); // R18
  assign flash_cmd_go = flash_cmd_valid && allowed; // R18

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flash_cmd_fail_q <= 1'b0;
    end
    else if (flash_cmd_valid)
    begin
      flash_cmd_fail_q <= !allowed; // R18
    end
  end

  // Assertion helper: first cycle after reset release
  logic started_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      started_q <= 1'b0;
    end
    else
    begin
      started_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_reset_fetch;
    !started_q |-> fetch_addr_q == 16'h0000;
  endproperty
  a_reset_fetch: assert property (p_reset_fetch) // R2
    else $error("fetch does not start at zero");

  property p_vector;
    irq_accept |=> fetch_addr_q == 16'h0003 +
                   16'({$past(irq_index), 3'b000});
  endproperty
  a_vector: assert property (p_vector) // R3
    else $error("interrupt vector wrong");

  property p_direct_upper;
    (byte_req.valid && !byte_req.reg_mode && !byte_req.indirect &&
     byte_req.addr[7] && byte_req.addr != 8'hA1 &&
     byte_req.addr != 8'h8E) |-> sfr_valid && !byte_to_ram;
  endproperty
  a_direct_upper: assert property (p_direct_upper) // R5
    else $error("direct upper access not sent to SFR space");

  sequence s_bit_write;
    bit_req.valid && bit_req.we && !bit_req.addr[7] &&
    !(byte_req.valid && byte_req.we);
  endsequence
  property p_bit_area;
    s_bit_write |=> iram_q[{4'h2, $past(bit_req.addr[6:3])}]
                    [$past(bit_req.addr[2:0])] == $past(bit_req.value);
  endproperty
  a_bit_area: assert property (p_bit_area) // R8
    else $error("bit area write lost");

  property p_bank;
    (byte_req.valid && byte_req.reg_mode && byte_req.we) |=>
      iram_q[{3'b000, $past(psw_bank), $past(byte_req.addr[2:0])}]
      == $past(byte_req.wdata);
  endproperty
  a_bank: assert property (p_bank) // R7
    else $error("register write outside selected bank");

  property p_aux_route;
    (movx_take && !aux_dis_q && movx_addr < 16'h0400) |->
      !xbus_start ##1 aux_done_q;
  endproperty
  a_aux_route: assert property (p_aux_route) // R10
    else $error("aux RAM access left the chip");

  property p_aux_block;
    (movx_take && aux_dis_q) |-> xbus_start && !aux_we;
  endproperty
  a_aux_block: assert property (p_aux_block) // R11
    else $error("aux RAM reached while disabled");

  property p_ri_high;
    (movx_req.via_ri && !aux_dis_q) |-> movx_addr[15:8] == 8'h00;
  endproperty
  a_ri_high: assert property (p_ri_high) // R13
    else $error("pointer high byte used for indirect access");

  property p_timing_write;
    (byte_req.valid && byte_req.we && !byte_req.indirect &&
     !byte_req.reg_mode && byte_req.addr == 8'hA1) |=>
      timing_q == ($past(byte_req.wdata) & 8'h37);
  endproperty
  a_timing_write: assert property (p_timing_write) // R15
    else $error("bus timing register not updated");

  property p_flash_guard;
    (flash_cmd_valid && !flash_req_isp && target != REGION_IAP) |->
      !flash_cmd_go ##1 flash_cmd_fail_q;
  endproperty
  a_flash_guard: assert property (p_flash_guard) // R18
    else $error("out-of-space flash command accepted");
endmodule

//--- src/data_memory_map_pkg.sv
// Purpose: shared constants and carriers for the data memory map block
// Assumes: 8-bit core, 16-bit external data address
// Notes:   addresses are RAM or SFR byte, bit, MOVX or program fetch addresses
package data_memory_map_pkg;
  localparam logic [7:0]  BUS_TIMING_ADDR  = 8'hA1;
  localparam logic [7:0]  AUX_CTRL_ADDR    = 8'h8E;
  localparam int          AUX_DISABLE_BIT  = 1;
  localparam logic [7:0]  BUS_TIMING_RESET = 8'h23;
  localparam logic        AUX_DIS_RESET    = 1'b0;
  localparam int          LATCH_LSB        = 4;
  localparam int          WIDTH_LSB        = 0;
  localparam logic [7:0]  TIMING_MASK      = 8'h37;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam logic [15:0] VECTOR_BASE      = 16'h0003;
  localparam int          VECTOR_SHIFT     = 3;
  localparam logic [15:0] AUX_LAST         = 16'h03FF;
  localparam logic [3:0]  BIT_AREA_HI      = 4'h2;
  localparam logic [2:0]  CAPTURE_WAIT     = 3'h1;

  typedef enum logic [1:0] {
    REGION_AP  = 2'b00,
    REGION_IAP = 2'b01,
    REGION_ISP = 2'b10
  } flash_region_e;

  typedef struct packed {
    logic       valid;
    logic       we;
    logic       indirect;
    logic       reg_mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } byte_req_s;

  typedef struct packed {
    logic       valid;
    logic       we;
    logic [7:0] addr;
    logic       value;
  } bit_req_s;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic        via_ri;
    logic [15:0] dptr;
    logic [7:0]  ri;
    logic [7:0]  wdata;
  } movx_req_s;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } xbus_cmd_s;
endpackage

//--- src/xbus_engine.sv
// Purpose: external data bus cycle with stretched latch and strobe phases
// Assumes: start only while busy is low
// Notes:   read data passes a two-stage synchroniser before capture
`timescale 1ns/1ps
module xbus_engine
  import data_memory_map_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       start,
  input  wire xbus_cmd_s  cmd,
  input  wire logic [1:0] latch_code,
  input  wire logic [2:0] width_code,
  output logic            busy,
  output logic            done_q,
  output logic [7:0]      rdata_q,
  input  wire logic [7:0] p0_in,
  output logic [7:0]      p0_out,
  output logic            p0_oe,
  output logic [7:0]      p2_out,
  output logic            ale,
  output logic            rd_n,
  output logic            wr_n
);
  typedef enum logic [2:0] {
    XB_IDLE   = 3'b000,
    XB_SETUP  = 3'b001,
    XB_HOLD   = 3'b010,
    XB_STROBE = 3'b011,
    XB_CAPT   = 3'b100
  } xb_state_e;

  xb_state_e  state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  xbus_cmd_s  cmd_q;
  logic [7:0] p0_meta_q, p0_sync_q;
  logic       last;
  logic       finish;

  assign last   = (cnt_q == 3'h0);
  assign busy   = (state_q != XB_IDLE);
  assign finish = last && ((state_q == XB_CAPT) ||
                  (state_q == XB_STROBE && cmd_q.we));

  // Pins decoded from the held command; address low byte on p0, high on p2
  assign ale    = (state_q == XB_SETUP); // R16
  assign p2_out = cmd_q.addr[15:8]; // R22
  assign p0_out = (state_q == XB_STROBE) ? cmd_q.wdata : cmd_q.addr[7:0];
  assign p0_oe  = (state_q == XB_SETUP) || (state_q == XB_HOLD) ||
                  (state_q == XB_STROBE && cmd_q.we); // R22
  assign rd_n   = !(state_q == XB_STROBE && !cmd_q.we); // R17
  assign wr_n   = !(state_q == XB_STROBE && cmd_q.we); // R17

  always_comb
  begin
    state_d = state_q;
    cnt_d   = last ? 3'h0 : cnt_q - 3'h1;
    unique case (state_q)
      XB_IDLE:
      begin
        if (start)
        begin
          state_d = XB_SETUP;
          cnt_d   = {1'b0, latch_code}; // R16
        end
      end
      XB_SETUP:
      begin
        if (last)
        begin
          state_d = XB_HOLD;
          cnt_d   = {1'b0, latch_code}; // R16
        end
      end
      XB_HOLD:
      begin
        if (last)
        begin
          state_d = XB_STROBE;
          cnt_d   = width_code; // R17
        end
      end
      XB_STROBE:
      begin
        if (last)
        begin
          state_d = cmd_q.we ? XB_IDLE : XB_CAPT;
          cnt_d   = CAPTURE_WAIT;
        end
      end
      XB_CAPT:
      begin
        if (last)
        begin
          state_d = XB_IDLE;
        end
      end
      default:
      begin
        state_d = XB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q   <= XB_IDLE;
      cnt_q     <= 3'h0;
      cmd_q     <= '0;
      p0_meta_q <= 8'h00;
      p0_sync_q <= 8'h00;
      done_q    <= 1'b0;
      rdata_q   <= 8'h00;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      p0_meta_q <= p0_in;
      p0_sync_q <= p0_meta_q;
      done_q    <= busy && finish;
      if (start && !busy)
      begin
        cmd_q <= cmd;
      end
      // Sync stage now holds the pin value sampled at the strobe's end
      if (state_q == XB_CAPT && last)
      begin
        rdata_q <= p0_sync_q; // R23
      end
    end
  end

  // Assertion helpers: length of the current latch-high and strobe phases
  logic [3:0] ale_len_q, strb_len_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ale_len_q  <= 4'h0;
      strb_len_q <= 4'h0;
    end
    else
    begin
      ale_len_q  <= ale ? ale_len_q + 4'h1 : 4'h0;
      strb_len_q <= (!rd_n || !wr_n) ? strb_len_q + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_latch_setup;
    $fell(ale) |-> ale_len_q == {2'b00, latch_code} + 4'h1;
  endproperty
  a_latch_setup: assert property (p_latch_setup) // R16
    else $error("address setup length wrong");

  sequence s_hold_phase;
    (!ale && p0_oe && !rd_n == 1'b0)[*1];
  endsequence
  property p_latch_hold;
    $fell(ale) |-> s_hold_phase ##0 (p0_out == cmd_q.addr[7:0]);
  endproperty
  a_latch_hold: assert property (p_latch_hold) // R22
    else $error("address not held after latch edge");

  property p_strobe_width;
    ($rose(rd_n) || $rose(wr_n)) |->
      strb_len_q == {1'b0, width_code} + 4'h1;
  endproperty
  a_strobe_width: assert property (p_strobe_width) // R17
    else $error("strobe width does not match code");
endmodule

//--- verification/data_memory_map_and_xbus_tb.sv
// Purpose: self-checking bench for data_memory_map_and_xbus
// Assumes: all inputs but p0_in change on the falling clock edge
// Notes:   SFR read data and SFR bit data are tied constants
`timescale 1ns/1ps
module data_memory_map_and_xbus_tb
  import data_memory_map_pkg::*;
;
  logic        clk, resetn, irq_accept, flash_cmd_valid, flash_req_isp;
  logic        isp_data_en, sfr_bit_rdata, bit_rdata_q, sfr_valid, sfr_we;
  logic        sfr_bit_valid, sfr_bit_we, sfr_bit_value, movx_ready;
  logic        movx_done, flash_cmd_go, flash_cmd_fail_q, p0_oe, ale;
  logic        rd_n, wr_n, sv;
  logic [15:0] pc_next, fetch_addr_q, flash_cmd_addr, sw;
  logic [7:0]  byte_rdata_q, sfr_addr, sfr_wdata, sfr_rdata, sfr_bit_byte;
  logic [7:0]  movx_rdata, p0_in, p0_out, p2_out;
  logic [2:0]  irq_index, sfr_bit_pos;
  logic [1:0]  psw_bank;
  logic [11:0] sb;
  byte_req_s   byte_req;
  bit_req_s    bit_req;
  movx_req_s   movx_req;
  int          fail_count, tests_run;

  assign sfr_rdata = 8'h6E;
  assign sfr_bit_rdata = 1'b1;

  data_memory_map_and_xbus i_dut (.clk, .resetn, .pc_next, .irq_accept,
    .irq_index, .fetch_addr_q, .psw_bank, .byte_req, .byte_rdata_q,
    .bit_req, .bit_rdata_q, .sfr_valid, .sfr_we, .sfr_addr, .sfr_wdata,
    .sfr_rdata, .sfr_bit_valid, .sfr_bit_we, .sfr_bit_byte, .sfr_bit_pos,
    .sfr_bit_value, .sfr_bit_rdata, .movx_req, .movx_ready, .movx_done,
    .movx_rdata, .flash_cmd_valid, .flash_cmd_addr, .flash_req_isp,
    .isp_data_en, .flash_cmd_go, .flash_cmd_fail_q, .p0_in, .p0_out,
    .p0_oe, .p2_out, .ale, .rd_n, .wr_n);

  xram_model i_mem (.clk, .p0_out, .p0_oe, .p2_out, .ale, .rd_n, .wr_n,
    .p0_in);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic bop(input logic w, i, r, input logic [7:0] a, d);
    @(negedge clk);
    byte_req = '{1'b1, w, i, r, a, d};
    #1 sv = sfr_valid;
    sw = {sfr_addr, sfr_wdata};
    @(negedge clk);
    byte_req.valid = 1'b0;
  endtask

  task automatic bitop(input logic w, input logic [7:0] a, input logic v);
    @(negedge clk);
    bit_req = '{1'b1, w, a, v};
    #1 sb = {sfr_bit_valid, sfr_bit_pos, sfr_bit_byte};
    @(negedge clk);
    bit_req.valid = 1'b0;
  endtask

  // Cycle of the done pulse, counted from the cycle the request is taken
  task automatic mx(input logic w, ri, input logic [15:0] p,
                    input logic [7:0] d, input int lat);
    int n;
    @(negedge clk);
    movx_req = '{1'b1, w, ri, p, p[7:0], d};
    n = 0;
    while (movx_ready !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    movx_req.valid = 1'b0;
    chk(lat == 1, movx_ready);
    n = 1;
    while (movx_done !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 300)
    begin
      fail_count++;
      results();
    end
    chk(16'(lat), 16'(n));
  endtask

  task automatic t_vec();
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      irq_accept = 1'b1;
      irq_index = 3'(i);
      @(negedge clk);
      irq_accept = 1'b0;
      chk(16'h0003 + 16'(8 * i), fetch_addr_q);
    end
    @(negedge clk);
    chk(pc_next, fetch_addr_q);
    $display("vectors done");
  endtask

  task automatic t_ram();
    psw_bank = 2'h2;
    bop(1, 0, 1, 8'h03, 8'h5A);
    bop(0, 0, 0, 8'h13, 8'h00);
    chk(8'h5A, byte_rdata_q);
    psw_bank = 2'h1;
    bop(1, 0, 0, 8'h0B, 8'h11);
    bop(0, 0, 1, 8'h03, 8'h00);
    chk(8'h11, byte_rdata_q);
    bop(1, 1, 0, 8'h90, 8'hC3);
    chk(1'b0, sv);
    bop(0, 0, 0, 8'h90, 8'h00);
    chk(1'b1, sv);
    chk(16'h9000, sw);
    chk(8'h6E, byte_rdata_q);
    bop(1, 0, 0, 8'h90, 8'h3C);
    chk(16'h903C, sw);
    bop(0, 1, 0, 8'h90, 8'h00);
    chk(8'hC3, byte_rdata_q);
    bop(1, 0, 0, 8'h40, 8'h77);
    bop(0, 1, 0, 8'h40, 8'h00);
    chk(8'h77, byte_rdata_q);
    $display("ram done");
  endtask

  task automatic t_bits();
    bop(1, 0, 0, 8'h21, 8'h00);
    bitop(1, 8'h0A, 1'b1);
    bop(0, 0, 0, 8'h21, 8'h00);
    chk(8'h04, byte_rdata_q);
    bop(1, 0, 0, 8'h2F, 8'h80);
    bitop(0, 8'h7F, 1'b0);
    chk(1'b1, bit_rdata_q);
    bitop(0, 8'h9B, 1'b0);
    chk(12'hB98, sb);
    chk(1'b1, bit_rdata_q);
    $display("bits done");
  endtask

  task automatic t_xbus();
    logic [7:0] tv [3] = '{8'h23, 8'h00, 8'hFF};
    logic [7:0] t;
    int lat;
    for (int k = 0; k < 3; k++)
    begin
      t = tv[k] & TIMING_MASK;
      if (k > 0)
        bop(1, 0, 0, BUS_TIMING_ADDR, tv[k]);
      bop(0, 0, 0, BUS_TIMING_ADDR, 8'h00);
      chk(t, byte_rdata_q);
      lat = 2 * (int'(t[5:4]) + 1) + int'(t[2:0]) + 2;
      mx(1, 0, 16'h1234 + 16'(k), 8'hA0 + 8'(k), lat);
      mx(0, 0, 16'h1234 + 16'(k), 8'h00, lat + 2);
      chk(8'hA0 + 8'(k), movx_rdata);
    end
    $display("xbus done");
  endtask

  task automatic t_aux();
    mx(1, 0, AUX_LAST, 8'h5C, 1);
    mx(0, 0, AUX_LAST, 8'h00, 1);
    chk(8'h5C, movx_rdata);
    mx(1, 1, 16'hAB05, 8'h3D, 1);
    mx(0, 0, 16'h0005, 8'h00, 1);
    chk(8'h3D, movx_rdata);
    mx(1, 0, 16'h0400, 8'h66, 17);
    mx(0, 0, 16'h0400, 8'h00, 19);
    chk(8'h66, movx_rdata);
    bop(1, 0, 0, AUX_CTRL_ADDR, 8'h02);
    mx(1, 0, 16'h0005, 8'h99, 17);
    mx(0, 0, 16'h0005, 8'h00, 19);
    chk(8'h99, movx_rdata);
    $display("aux done");
  endtask

  task automatic t_flash();
    logic [15:0] fa [6] = '{16'h9000, 16'h1000, 16'hD000,
                            16'h1000, 16'hD000, 16'hD000};
    logic [5:0]  ok = 6'b101001;
    for (int k = 0; k < 6; k++)
    begin
      @(negedge clk);
      flash_req_isp = (k > 2);
      isp_data_en = (k == 5);
      flash_cmd_valid = 1'b1;
      flash_cmd_addr = fa[k];
      #1 chk(ok[k], flash_cmd_go);
      @(negedge clk);
      flash_cmd_valid = 1'b0;
      chk(!ok[k], flash_cmd_fail_q);
    end
    $display("flash done");
  endtask

  initial
  begin
    resetn = 1'b0;
    irq_accept = 1'b0;
    irq_index = 3'h0;
    pc_next = 16'h0123;
    psw_bank = 2'h0;
    byte_req = '0;
    bit_req = '0;
    movx_req = '0;
    flash_cmd_valid = 1'b0;
    flash_cmd_addr = 16'h0000;
    flash_req_isp = 1'b0;
    isp_data_en = 1'b0;
    fail_count = 0;
    tests_run = 0;
    repeat (8) @(negedge clk);
    chk(RESET_VECTOR, fetch_addr_q);
    chk(3'b011, {ale, rd_n, wr_n});
    resetn = 1'b1;
    t_vec();
    t_ram();
    t_bits();
    t_xbus();
    t_aux();
    t_flash();
    results();
  end
endmodule

//--- verification/xram_model.sv
// Purpose: external byte-wide data RAM on the multiplexed bus
// Assumes: low address is taken while the latch strobe is high
// Notes:   released p0 toggles every cycle so stale data never matches
`timescale 1ns/1ps
module xram_model (
  input  wire logic       clk,
  input  wire logic [7:0] p0_out,
  input  wire logic       p0_oe,
  input  wire logic [7:0] p2_out,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  output logic      [7:0] p0_in
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lo_q;
  logic [7:0]  last_q = 8'h5A;
  logic [15:0] addr;

  assign addr = {p2_out, lo_q};
  // Data answers at once; the design must wait out its own strobe
  assign p0_in = p0_oe ? p0_out : !rd_n ? mem[addr] : ~last_q;

  always @(posedge clk)
  begin
    last_q <= p0_in;
    if (ale)
      lo_q <= p0_out;
    if (!wr_n)
      mem[addr] <= p0_out;
  end
endmodule
